// ===== pdcc_consts.vh
// register map, field positions and reset values of the pll/cluster bank
`ifndef PDCC_CONSTS_VH
`define PDCC_CONSTS_VH

`define PDCC_PLL_COUNT      7
`define PDCC_PLL_CTRL_BASE  8'h00
`define PDCC_PLL_VAL_BASE   8'h04
`define PDCC_PLL_STRIDE     8'h08
`define PDCC_CORE_CFG_OFS   8'h38
`define PDCC_SYS_CFG_OFS    8'h3c

`define PDCC_OD_MSB         11
`define PDCC_OD_LSB         8
`define PDCC_RD_MSB         5
`define PDCC_RD_LSB         0
`define PDCC_FB_MSB         28
`define PDCC_FB_LSB         16
`define PDCC_BYP_BIT        0

// per pll, index 0 = system, memory, display, big0, big1, little0, little1
`define PDCC_OD_RST_ALL     28'h1111d51
`define PDCC_RD_RST_ALL     42'h1170e3490cd
`define PDCC_FB_RST_ALL     91'h7dc73e21b117873417e22f

`define PDCC_SECURE_NONINVASIVE_DEBUG_EN_LSB    28
`define PDCC_SECURE_INVASIVE_DEBUG_EN_LSB     24
`define PDCC_NONINVASIVE_DEBUG_EN_LSB      20
`define PDCC_INVASIVE_DEBUG_EN_LSB      16
`define PDCC_TE_LSB         12
`define PDCC_VEC_LSB        8
`define PDCC_IMIN_BIT       7
`define PDCC_CID_LSB        0
`define PDCC_CORE_CFG_RST   32'h33330000

`define PDCC_L2OFF_BIT      30
`define PDCC_MAINT_BIT      29
`define PDCC_OUTER_BIT      28
`define PDCC_INNER_BIT      27
`define PDCC_BAROFF_BIT     26
`define PDCC_WIDTH_BIT      24
`define PDCC_DMA_BIT        23
`define PDCC_REMAP_BIT      22
`define PDCC_AWUSER_LSB     16
`define PDCC_ARUSER_LSB     10
`define PDCC_OVR_BIT        9
`define PDCC_PINACT_BIT     8
`define PDCC_SINACT_BIT     7
`define PDCC_SYSBLK_LSB     4
`define PDCC_END_LSB        0
`define PDCC_SYS_CFG_RST    32'h183ffc00

`define PDCC_CORE_CFG_MASK  32'h33333380
`define PDCC_CORE_CID_MASK  32'h0000000f
`define PDCC_SYS_CFG_MASK   32'h7dffffb3

`define PDCC_REMAP_WIN_HI   12'h003
`define PDCC_REMAP_ADDR_BIT 28

`endif

// ===== pdcc_pll_regs.v
// one pll's value and control register pair with divider outputs
`timescale 1ns/100ps
module pdcc_pll_regs
#(
    parameter [3:0]  OD_RST = 4'h1,
    parameter [5:0]  RD_RST = 6'h0d,
    parameter [12:0] FB_RST = 13'h022f
)
(
    // clock and synchronised reset
    input  wire        clk,
    input  wire        rstSync_n,
    // write strobes from the bus slave
    input  wire        wrValue,
    input  wire        wrCtrl,
    input  wire [31:0] wrData,
    input  wire [3:0]  byteEn,
    // readback words
    output wire [31:0] valueWord,
    output wire [31:0] ctrlWord,
    // to the pll
    output reg  [3:0]  outputDivider_reg,
    output reg  [5:0]  referenceDivider_reg,
    output reg  [12:0] feedbackDivider_reg,
    output reg         hardBypass_reg,
    output reg  [4:0]  outputFactor_reg,
    output reg  [6:0]  referenceFactor_reg,
    output reg  [13:0] feedbackFactor_reg
);
`include "pdcc_consts.vh"

    function [31:0] byteMerge;
        input [31:0] oldWord;
        input [31:0] newWord;
        input [3:0]  be;
        integer k;
        begin
            byteMerge = oldWord;
            for (k = 0; k < 4; k = k + 1)
                if (be[k])
                    byteMerge[k*8 +: 8] = newWord[k*8 +: 8];
        end
    endfunction

    wire [31:0] valueMerged;
    wire [31:0] ctrlMerged;

    // reserved bits never stored, so they read as zero
    assign valueWord = {20'h00000, outputDivider_reg, 2'b00,
                        referenceDivider_reg};
    assign ctrlWord  = {3'b000, feedbackDivider_reg, 15'h0000,
                        hardBypass_reg};
    assign valueMerged = byteMerge(valueWord, wrData, byteEn);
    assign ctrlMerged  = byteMerge(ctrlWord, wrData, byteEn);

    always @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            outputDivider_reg    <= OD_RST;
            referenceDivider_reg <= RD_RST;
            feedbackDivider_reg  <= FB_RST;
            hardBypass_reg       <= 1'b0;
        end
        else
        begin
            if (wrValue)
            begin
                outputDivider_reg <=
                    valueMerged[`PDCC_OD_MSB:`PDCC_OD_LSB];
                referenceDivider_reg <=
                    valueMerged[`PDCC_RD_MSB:`PDCC_RD_LSB];
            end
            if (wrCtrl)
            begin
                feedbackDivider_reg <=
                    ctrlMerged[`PDCC_FB_MSB:`PDCC_FB_LSB];
                hardBypass_reg <= ctrlMerged[`PDCC_BYP_BIT];
            end
        end
    end

    // divisors are field plus one; one cycle behind the fields
    always @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            outputFactor_reg    <= {1'b0, OD_RST} + 5'h01;
            referenceFactor_reg <= {1'b0, RD_RST} + 7'h01;
            feedbackFactor_reg  <= {1'b0, FB_RST} + 14'h0001;
        end
        else
        begin
            outputFactor_reg    <= {1'b0, outputDivider_reg} + 5'h01;
            referenceFactor_reg <= {1'b0, referenceDivider_reg} + 7'h01;
            feedbackFactor_reg  <= {1'b0, feedbackDivider_reg} + 14'h0001;
        end
    end
endmodule

// ===== pdcc_config_regs.v
// pll divider and big-cluster configuration bank on an avalon-mm slave
// How it works
// - pll value register holds 4-bit output divider, divisor is field+1
// - pll value register holds 6-bit reference divider, divisor field+1
// - output divider resets 1 except memory 5 and display 13
// - reference divider resets to its own value for each pll
// - two bits drive secure noninvasive debug enables, one enables, reset 11
// - two bits drive secure invasive debug enables, one enables, reset 11
// - two bits drive noninvasive debug; stored one disables, reset 11
// - two bits drive invasive debug enables, one enables, reset 11
// - two bits pick exception instruction state per core, reset 00
// - two bits pick low or high vector base per core, reset 00
// - one bit sets icache minimum line, 32 or 64 bytes, reset 0
// - four bits give the cluster identifier, reset 0000
// - one bit stops l2 invalidate at reset when set, reset 0
// - three broadcast enables: maintenance 0, outer 1, inner 1 at reset
// - one bit suppresses barrier broadcast when set, reset 0
// - one bit selects coherency port width, 0 128-bit, 1 64-bit
// - one bit routes dma straight to the coherency port when set
// - one bit overrides address bit 28 inside the 0x3 window
// - user fields drive sidebands; upper four follow cache unless override
// - two bits deactivate coherency port and snoop interface, reset 0
// - two bits block secure system register writes per core, reset 00
// - two bits pick endianness per core at reset, reset 00
// - pll control register holds feedback divider, divisor field+1
`timescale 1ns/100ps
module pdcc_config_regs
#(
    parameter PLL_COUNT = 7
)
(
    // clock and reset
    input  wire                   ref_clk,
    input  wire                   rst_n,
    // avalon-mm slave, byte address
    input  wire [7:0]             avs_address,
    input  wire                   avs_read,
    input  wire                   avs_write,
    input  wire [31:0]            avs_writedata,
    input  wire [3:0]             avs_byteenable,
    output reg  [31:0]            avs_readdata,
    output reg                    avs_waitrequest,
    // pll dividers, pll i in slice i
    output wire [PLL_COUNT*4-1:0]  outputDivider,
    output wire [PLL_COUNT*6-1:0]  referenceDivider,
    output wire [PLL_COUNT*13-1:0] feedbackDivider,
    output wire [PLL_COUNT-1:0]    hardBypass,
    output wire [PLL_COUNT*5-1:0]  outputFactor,
    output wire [PLL_COUNT*7-1:0]  referenceFactor,
    output wire [PLL_COUNT*14-1:0] feedbackFactor,
    // cluster core tie-offs
    output reg  [1:0]             secureNoninvasiveDebugEn,
    output reg  [1:0]             secureInvasiveDebugEn,
    output reg  [1:0]             noninvasiveDebugEn,
    output reg  [1:0]             invasiveDebugEn,
    output reg  [1:0]             exceptionStateSelect,
    output reg  [1:0]             highVectorSelect,
    output reg                    icacheMinLine,
    output reg  [3:0]             clusterIdentifier,
    // cluster system tie-offs
    output reg                    l2ResetInvalidateOff,
    output reg                    maintBroadcastEn,
    output reg                    outerShareBroadcastEn,
    output reg                    innerShareBroadcastEn,
    output reg                    barrierBroadcastOff,
    output reg                    coherencyPortWidthSel,
    output reg                    directDmaRoute,
    output reg                    portInactive,
    output reg                    snoopInactive,
    output reg  [1:0]             secureSysregWriteBlock,
    output reg  [1:0]             endianSelect,
    // coherency port sidebands and address remap
    input  wire [3:0]             portAwCache,
    input  wire [3:0]             portArCache,
    input  wire [39:0]            portAddrIn,
    output reg  [5:0]             portAwUser,
    output reg  [5:0]             portArUser,
    output reg  [39:0]            portAddrOut
);
`include "pdcc_consts.vh"

    localparam [PLL_COUNT*4-1:0]  OD_RST_ALL = `PDCC_OD_RST_ALL;
    localparam [PLL_COUNT*6-1:0]  RD_RST_ALL = `PDCC_RD_RST_ALL;
    localparam [PLL_COUNT*13-1:0] FB_RST_ALL = `PDCC_FB_RST_ALL;

    // same byte-lane merge as the pll registers
    function [31:0] byteMerge;
        input [31:0] oldWord;
        input [31:0] newWord;
        input [3:0]  be;
        integer k;
        begin
            byteMerge = oldWord;
            for (k = 0; k < 4; k = k + 1)
                if (be[k])
                    byteMerge[k*8 +: 8] = newWord[k*8 +: 8];
        end
    endfunction

    reg  [1:0]  rstPipe_reg;
    wire        rstSync_n;
    reg  [31:0] coreCfg_reg;
    reg  [31:0] sysCfg_reg;
    reg  [31:0] readMux;
    reg         addrMapped;
    wire        request;
    wire        commit;
    wire        wrCommit;
    wire [31:0] coreMerged;
    wire [31:0] sysMerged;
    wire [31:0] coreCfg_next;
    wire [31:0] sysCfg_next;
    wire [PLL_COUNT*32-1:0] valueWords;
    wire [PLL_COUNT*32-1:0] ctrlWords;
    integer     j;

    // reset released through two flops; async assertion, sync release
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rstPipe_reg <= 2'b00;
        else
            rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
    assign rstSync_n = rstPipe_reg[1];

    // one wait state: waitrequest low for exactly one cycle per request
    assign request  = avs_read | avs_write;
    assign commit   = request & ~avs_waitrequest;
    assign wrCommit = avs_write & ~avs_waitrequest;

    always @(posedge ref_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            avs_waitrequest <= 1'b1;
        else if (commit)
            avs_waitrequest <= 1'b1;
        else if (request)
            avs_waitrequest <= 1'b0;
    end

    // read word captured as waitrequest falls, stable at the taking edge
    always @*
    begin
        readMux    = 32'h00000000;
        addrMapped = 1'b0;
        for (j = 0; j < PLL_COUNT; j = j + 1)
        begin
            if (avs_address == `PDCC_PLL_CTRL_BASE + j * `PDCC_PLL_STRIDE)
            begin
                readMux    = ctrlWords[j*32 +: 32];
                addrMapped = 1'b1;
            end
            if (avs_address == `PDCC_PLL_VAL_BASE + j * `PDCC_PLL_STRIDE)
            begin
                readMux    = valueWords[j*32 +: 32];
                addrMapped = 1'b1;
            end
        end
        if (avs_address == `PDCC_CORE_CFG_OFS)
        begin
            readMux    = coreCfg_reg;
            addrMapped = 1'b1;
        end
        if (avs_address == `PDCC_SYS_CFG_OFS)
        begin
            readMux    = sysCfg_reg;
            addrMapped = 1'b1;
        end
    end

    always @(posedge ref_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            avs_readdata <= 32'h00000000;
        else if (avs_read & avs_waitrequest)
            avs_readdata <= addrMapped ? readMux : 32'h00000000;
    end

    genvar g;
    generate
        for (g = 0; g < PLL_COUNT; g = g + 1)
        begin : pllBank
            pdcc_pll_regs
            #(
                .OD_RST (OD_RST_ALL[g*4 +: 4]),
                .RD_RST (RD_RST_ALL[g*6 +: 6]),
                .FB_RST (FB_RST_ALL[g*13 +: 13])
            )
            pllRegs
            (
                .clk                  (ref_clk),
                .rstSync_n            (rstSync_n),
                .wrValue              (wrCommit & (avs_address ==
                    `PDCC_PLL_VAL_BASE + g * `PDCC_PLL_STRIDE)),
                .wrCtrl               (wrCommit & (avs_address ==
                    `PDCC_PLL_CTRL_BASE + g * `PDCC_PLL_STRIDE)),
                .wrData               (avs_writedata),
                .byteEn               (avs_byteenable),
                .valueWord            (valueWords[g*32 +: 32]),
                .ctrlWord             (ctrlWords[g*32 +: 32]),
                .outputDivider_reg    (outputDivider[g*4 +: 4]),
                .referenceDivider_reg (referenceDivider[g*6 +: 6]),
                .feedbackDivider_reg  (feedbackDivider[g*13 +: 13]),
                .hardBypass_reg       (hardBypass[g]),
                .outputFactor_reg     (outputFactor[g*5 +: 5]),
                .referenceFactor_reg  (referenceFactor[g*7 +: 7]),
                .feedbackFactor_reg   (feedbackFactor[g*14 +: 14])
            );
        end
    endgenerate

    // cluster words; reserved bits masked so they stay zero
    assign coreMerged = byteMerge(coreCfg_reg, avs_writedata,
                                  avs_byteenable);
    assign sysMerged  = byteMerge(sysCfg_reg, avs_writedata,
                                  avs_byteenable);
    assign coreCfg_next = coreMerged &
        (`PDCC_CORE_CFG_MASK | `PDCC_CORE_CID_MASK);
    assign sysCfg_next  = sysMerged & `PDCC_SYS_CFG_MASK;

    always @(posedge ref_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            coreCfg_reg <= `PDCC_CORE_CFG_RST;
            sysCfg_reg  <= `PDCC_SYS_CFG_RST;
        end
        else
        begin
            if (wrCommit & (avs_address == `PDCC_CORE_CFG_OFS))
                coreCfg_reg <= coreCfg_next;
            if (wrCommit & (avs_address == `PDCC_SYS_CFG_OFS))
                sysCfg_reg <= sysCfg_next;
        end
    end

    // tie-off outputs follow the stored words one cycle later
    always @(posedge ref_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            secureNoninvasiveDebugEn <= 2'b11;
            secureInvasiveDebugEn    <= 2'b11;
            noninvasiveDebugEn       <= 2'b00;
            invasiveDebugEn          <= 2'b11;
            exceptionStateSelect     <= 2'b00;
            highVectorSelect         <= 2'b00;
            icacheMinLine            <= 1'b0;
            clusterIdentifier        <= 4'h0;
            l2ResetInvalidateOff     <= 1'b0;
            maintBroadcastEn         <= 1'b0;
            outerShareBroadcastEn    <= 1'b1;
            innerShareBroadcastEn    <= 1'b1;
            barrierBroadcastOff      <= 1'b0;
            coherencyPortWidthSel    <= 1'b0;
            directDmaRoute           <= 1'b0;
            portInactive             <= 1'b0;
            snoopInactive            <= 1'b0;
            secureSysregWriteBlock   <= 2'b00;
            endianSelect             <= 2'b00;
        end
        else
        begin
            secureNoninvasiveDebugEn <=
                coreCfg_reg[`PDCC_SECURE_NONINVASIVE_DEBUG_EN_LSB +: 2];
            secureInvasiveDebugEn <=
                coreCfg_reg[`PDCC_SECURE_INVASIVE_DEBUG_EN_LSB +: 2];
            // stored one means disabled, so the enable is inverted
            noninvasiveDebugEn <=
                ~coreCfg_reg[`PDCC_NONINVASIVE_DEBUG_EN_LSB +: 2];
            invasiveDebugEn <=
                coreCfg_reg[`PDCC_INVASIVE_DEBUG_EN_LSB +: 2];
            exceptionStateSelect <=
                coreCfg_reg[`PDCC_TE_LSB +: 2];
            highVectorSelect <=
                coreCfg_reg[`PDCC_VEC_LSB +: 2];
            icacheMinLine <= coreCfg_reg[`PDCC_IMIN_BIT];
            clusterIdentifier <=
                coreCfg_reg[`PDCC_CID_LSB +: 4];
            l2ResetInvalidateOff <=
                sysCfg_reg[`PDCC_L2OFF_BIT];
            maintBroadcastEn <= sysCfg_reg[`PDCC_MAINT_BIT];
            outerShareBroadcastEn <=
                sysCfg_reg[`PDCC_OUTER_BIT];
            innerShareBroadcastEn <=
                sysCfg_reg[`PDCC_INNER_BIT];
            barrierBroadcastOff <=
                sysCfg_reg[`PDCC_BAROFF_BIT];
            coherencyPortWidthSel <=
                sysCfg_reg[`PDCC_WIDTH_BIT];
            directDmaRoute <= sysCfg_reg[`PDCC_DMA_BIT];
            portInactive  <= sysCfg_reg[`PDCC_PINACT_BIT];
            snoopInactive <= sysCfg_reg[`PDCC_SINACT_BIT];
            secureSysregWriteBlock <=
                sysCfg_reg[`PDCC_SYSBLK_LSB +: 2];
            endianSelect <= sysCfg_reg[`PDCC_END_LSB +: 2];
        end
    end

    // sidebands and remap are registered: one cycle of latency on the port
    always @(posedge ref_clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            portAwUser  <= 6'h3f;
            portArUser  <= 6'h3f;
            portAddrOut <= 40'h0000000000;
        end
        else
        begin
            portAwUser[1:0] <= sysCfg_reg[`PDCC_AWUSER_LSB +: 2];
            portArUser[1:0] <= sysCfg_reg[`PDCC_ARUSER_LSB +: 2];
            if (sysCfg_reg[`PDCC_OVR_BIT])
            begin
                portAwUser[5:2] <=
                    sysCfg_reg[`PDCC_AWUSER_LSB + 2 +: 4];
                portArUser[5:2] <=
                    sysCfg_reg[`PDCC_ARUSER_LSB + 2 +: 4];
            end
            else
            begin
                portAwUser[5:2] <= portAwCache;
                portArUser[5:2] <= portArCache;
            end
            portAddrOut <= portAddrIn;
            if (portAddrIn[39:28] == `PDCC_REMAP_WIN_HI)
                portAddrOut[`PDCC_REMAP_ADDR_BIT] <=
                    sysCfg_reg[`PDCC_REMAP_BIT];
        end
    end
endmodule

// ===== pdcc_config_regs_props.sv
// concurrent checks on the pll/cluster bank ports
`timescale 1ns/100ps
module pdcc_config_regs_props
#(
    parameter PLL_COUNT = 7
)
(
    // clock, reset, bus
    input wire                    ref_clk,
    input wire                    rst_n,
    input wire [7:0]              avs_address,
    input wire                    avs_read,
    input wire                    avs_write,
    input wire [31:0]             avs_readdata,
    input wire                    avs_waitrequest,
    // pll and port outputs
    input wire [PLL_COUNT*4-1:0]  outputDivider,
    input wire [PLL_COUNT*6-1:0]  referenceDivider,
    input wire [PLL_COUNT*13-1:0] feedbackDivider,
    input wire [PLL_COUNT*5-1:0]  outputFactor,
    input wire [PLL_COUNT*7-1:0]  referenceFactor,
    input wire [PLL_COUNT*14-1:0] feedbackFactor,
    input wire [1:0]              endianSelect,
    input wire [39:0]             portAddrIn,
    input wire [39:0]             portAddrOut
);
    // the bank runs on a synchronised reset copy, so wait it out
    reg  [3:0] live_reg;
    wire       wrAcc = avs_write & ~avs_waitrequest;
    always @(posedge ref_clk or negedge rst_n)
        if (!rst_n)
            live_reg <= 4'h0;
        else
            live_reg <= {live_reg[2:0], 1'b1};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!live_reg[3]);
    chk_wait_one: assert property ((avs_read | avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered in time");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_unmapped_zero: assert property (avs_read && avs_waitrequest &&
        avs_address > 8'h3f |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_div_write: assert property ($changed(outputDivider) ||
        $changed(referenceDivider) |-> $past(wrAcc))
        else $error("divider moved without a write");
    chk_tie_write: assert property ($changed(endianSelect)
        |-> $past(wrAcc, 2)) else $error("endian moved without a write");
    chk_addr_pass: assert property (portAddrIn[39:28] != 12'h003
        |=> portAddrOut == $past(portAddrIn))
        else $error("address outside window altered");
    for (genvar p = 0; p < PLL_COUNT; p++)
    begin : g_pll
        chk_od_factor: assert property (outputFactor[p*5+:5] ==
            $past(outputDivider[p*4+:4]) + 5'h1) else $error("od factor");
        chk_rd_factor: assert property (referenceFactor[p*7+:7] ==
            $past(referenceDivider[p*6+:6]) + 7'h1) else $error("rd factor");
        chk_fb_factor: assert property (feedbackFactor[p*14+:14] ==
            $past(feedbackDivider[p*13+:13]) + 14'h1) else $error("fb factor");
    end
endmodule
bind pdcc_config_regs pdcc_config_regs_props #(.PLL_COUNT(PLL_COUNT)) chk_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .outputDivider(outputDivider),
    .referenceDivider(referenceDivider), .feedbackDivider(feedbackDivider),
    .outputFactor(outputFactor), .referenceFactor(referenceFactor),
    .feedbackFactor(feedbackFactor), .endianSelect(endianSelect),
    .portAddrIn(portAddrIn), .portAddrOut(portAddrOut));

// ===== pdcc_port_model.sv
// far-side coherency port stand-in: cache attributes and addresses
`timescale 1ns/100ps
module pdcc_port_model
(
    // clock and bench controls
    input  wire         ref_clk,
    input  wire         freeze,
    input  wire         winMode,
    // towards the bank
    output logic [3:0]  awCache = 4'h0,
    output logic [3:0]  arCache = 4'h0,
    output logic [39:0] addr    = 40'h0
);
    // new values every cycle so a stale sideband shows; freeze holds them
    always @(posedge ref_clk)
        if (!freeze)
        begin
            awCache <= 4'($urandom);
            arCache <= 4'($urandom);
            addr    <= {winMode ? 12'h003 : {1'b1, 11'($urandom)},
                        28'($urandom)};
        end
endmodule

// ===== pdcc_config_regs_test.sv
// self-checking bench for the pll/cluster configuration bank
`timescale 1ns/100ps
module pdcc_config_regs_test;
    logic        ref_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
    logic        freeze = 0, winMode = 0;
    logic [7:0]  avs_address = 0;
    logic [31:0] avs_writedata = 0, q, d, sh [16];
    logic [3:0]  avs_byteenable = 0, awCache, arCache;
    logic [39:0] portAddrIn;
    int          fail_count = 0, num_checks = 0;
    int          odT [7] = '{1, 5, 13, 1, 1, 1, 1};
    int          rdT [7] = '{13, 3, 9, 13, 14, 28, 17};
    int          fbT [7] = '{559, 191, 461, 559, 539, 927, 503};
    wire [31:0]  avs_readdata;
    wire         avs_waitrequest, imin, l2, mnt, ou, inn, bar, wid, dma;
    wire         pIn, sIn;
    wire [1:0]   sNi, sI, nI, dbg, exc, vec, blk, endn;
    wire [3:0]   cid;
    wire [5:0]   awU, arU;
    wire [39:0]  addrO;
    wire [27:0]  od;
    wire [41:0]  rd;
    wire [90:0]  fb;
    wire [6:0]   hb;
    wire [16:0]  coreT = {sNi, sI, nI, dbg, exc, vec, imin, cid};
    wire [12:0]  sysT = {l2, mnt, ou, inn, bar, wid, dma, pIn, sIn, blk, endn};
    pdcc_config_regs dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .outputDivider(od),
        .referenceDivider(rd), .feedbackDivider(fb), .hardBypass(hb),
        .outputFactor(), .referenceFactor(), .feedbackFactor(),
        .secureNoninvasiveDebugEn(sNi), .secureInvasiveDebugEn(sI),
        .noninvasiveDebugEn(nI), .invasiveDebugEn(dbg),
        .exceptionStateSelect(exc), .highVectorSelect(vec),
        .icacheMinLine(imin), .clusterIdentifier(cid),
        .l2ResetInvalidateOff(l2), .maintBroadcastEn(mnt),
        .outerShareBroadcastEn(ou), .innerShareBroadcastEn(inn),
        .barrierBroadcastOff(bar), .coherencyPortWidthSel(wid),
        .directDmaRoute(dma), .portInactive(pIn), .snoopInactive(sIn),
        .secureSysregWriteBlock(blk), .endianSelect(endn),
        .portAwCache(awCache), .portArCache(arCache),
        .portAddrIn(portAddrIn), .portAwUser(awU), .portArUser(arU),
        .portAddrOut(addrO));
    pdcc_port_model far_u (.ref_clk(ref_clk), .freeze(freeze),
        .winMode(winMode), .awCache(awCache), .arCache(arCache),
        .addr(portAddrIn));
    initial forever #20 ref_clk = ~ref_clk;
    function logic [31:0] rmask(input logic [7:0] a);
        return a == 8'h38 ? 32'h3333338f : a == 8'h3c ? 32'h7dffffb3 :
               a[2] ? 32'h00000f3f : 32'h1fff0001;
    endfunction
    task chk(input logic [90:0] got, input logic [90:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one avalon access; the shadow copy follows every accepted write
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             input logic [3:0] be);
        int n;
        logic [31:0] m;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        avs_byteenable <= be;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0 && n < 50)
        begin
            n++;
            @(posedge ref_clk);
        end
        if (n >= 50)
            fail_count++;
        q = avs_readdata;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & rmask(a);
        if (wr && a < 8'h40)
            sh[a[5:2]] = (sh[a[5:2]] & ~m) | (wd & m);
        if (!wr)
            chk(q, a < 8'h40 ? sh[a[5:2]] : 32'h0);
        avs_read <= 0;
        avs_write <= 0;
        @(posedge ref_clk);
    endtask
    task outs;
        logic [31:0] c, s;
        c = sh[14];
        s = sh[15];
        chk(coreT, {c[29:28], c[25:24], ~c[21:20], c[17:16], c[13:12],
            c[9:8], c[7], c[3:0]});
        chk(sysT, {s[30:26], s[24:23], s[8:7], s[5:4], s[1:0]});
        for (int p = 0; p < 7; p++)
        begin
            chk(od[p*4+:4], sh[2*p+1][11:8]);
            chk(rd[p*6+:6], sh[2*p+1][5:0]);
            chk({hb[p], fb[p*13+:13]}, {sh[2*p][0], sh[2*p][28:16]});
        end
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        give_verdict;
    end
    initial
    begin
        void'($urandom(4072));
        for (int i = 0; i < 7; i++)
        begin
            sh[2*i] = {fbT[i][15:0], 16'h0};
            sh[2*i+1] = {20'h0, odT[i][3:0], 2'b0, rdT[i][5:0]};
        end
        sh[14] = 32'h33330000;
        sh[15] = 32'h183ffc00;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1;
        repeat (3) @(posedge ref_clk);
        outs;
        for (int i = 0; i < 20; i++)
            bus(0, 8'(i * 4), 32'h0, 4'h0);
        bus(0, 8'hfc, 32'h0, 4'h0);
        for (int i = 0; i < 60; i++)
        begin
            d = 8'(($urandom % 18) * 4);
            bus(1, d[7:0], $urandom, 4'($urandom));
            bus(0, d[7:0], 32'h0, 4'h0);
        end
        outs;
        for (int k = 0; k < 8; k++)
        begin
            d = $urandom;
            d[9] = k[0];
            d[22] = k[1];
            bus(1, 8'h3c, d, 4'hf);
            winMode <= k[2];
            @(posedge ref_clk);
            freeze <= 1;
            repeat (3) @(posedge ref_clk);
            d = sh[15];
            chk(awU, {d[9] ? d[21:18] : awCache, d[17:16]});
            chk(arU, {d[9] ? d[15:12] : arCache, d[11:10]});
            chk(addrO, k[2] ? {portAddrIn[39:29], d[22], portAddrIn[27:0]}
                : portAddrIn);
            freeze <= 0;
        end
        give_verdict;
    end
endmodule
